// ===== manchester_frame_receiver.sv
// Receive data manager: on/off sequencing, identifier and header search, serial output.
// Assumes a free-running link clock and pins that are asynchronous to core_clk_i.
//
// Overview of operation
// (RULE1) Decoder disabled: raw data straight to serial data, clock low, no framing.
// (RULE2) Manchester bit: data in first half, inverse in second half.
// (RULE3) Sender keeps Manchester duty cycle between 47 and 53 percent.
// (RULE4) Telegram order: preamble, identifier, header, data, end marker.
// (RULE5) Sender puts a preamble before the first identifier for settling.
// (RULE6) Preamble omitted only when more than two identifiers are sent.
// (RULE7) Recent decoded bits compared with stored identifier, length by length field.
// (RULE8) Identifier or its bitwise complement both count as a match.
// (RULE9) Then header compared by its length field; complement match inverts output.
// (RULE10) Sender starts data right after header, same bit rate.
// (RULE11) Two equal levels, a Manchester violation, mark end of message.
// (RULE12) Under strobe oscillator, identifier burst spans two receiver-on cycles.
// (RULE13) Off state keeps receiver off; wake pin low holds it there.
// (RULE14) Identifier wait advances on match, else off at on-time end unless wake high.
// (RULE15) Header wait returns off after 256 bits without header.
// (RULE16) After header, output bits with clock until end of message.
// (RULE17) End mid-byte: dummy bits appended up to a multiple of eight.
// (RULE18) With oscillator, wake low forces off from anywhere; wake pin overrides.
// (RULE19) Without oscillator, standby until wake pin high, then identifier wait.
// (RULE20) Without oscillator, stay in waits while wake high; advance only on match.
// (RULE21) Without oscillator, wake low returns to standby; config low forces config.
// (RULE22) No data taken during settling interval after receiver turns on.
// (RULE23) Controller sizes on window for settling plus two identifiers.
// (RULE24) Output data bit is valid on the falling clock edge.
// (RULE25) Bit period from shortest pulse, continually updated to incoming rate.
// (RULE26) Output bytes go most significant bit first.
// (RULE27) Matching is a sliding compare once per recovered bit.
`timescale 1ns/100ps
`default_nettype none
module manchester_frame_receiver #(
	parameter int ON_UNIT_CYCLES = mfr_pkg::ON_UNIT_CYCLES_DFLT, // Core clocks per on-time unit
	parameter int SETTLE_CYCLES = mfr_pkg::SETTLE_CYCLES_DFLT // Core clocks of settling
) (
	input wire logic core_clk_i, // Core clock, 100 MHz
	input wire logic srst_i, // Synchronous reset, active high
	input wire logic link_clk_i, // Digital link clock
	input wire logic raw_data_i, // Demodulated data pin
	input wire logic decoder_enable_i, // Data manager enable
	input wire logic strobe_osc_enable_i, // Strobe oscillator enable
	input wire logic config_select_n_i, // Config select pin, low forces config
	input wire logic strobe_high_i, // Wake pin sensed high
	input wire logic strobe_low_i, // Wake pin sensed driven low
	input wire logic osc_wake_i, // Off counter expired
	input wire logic [15:0] id_pattern_i, // Stored identifier
	input wire logic [1:0] id_length_field_i, // Identifier length code
	input wire logic [15:0] header_pattern_i, // Stored header
	input wire logic [1:0] header_length_field_i, // Header length code
	input wire logic [3:0] receiver_on_time_field_i, // On time in units
	output logic mosi_o, // Serial data out
	output logic sclk_o, // Recovered serial clock
	output logic rx_on_o, // Receiver powered
	output logic config_mode_o, // Configuration mode
	output logic spi_master_o, // Serial port active as master
	output logic data_inverted_o // Complemented header seen
);

	typedef struct packed {
		logic [4:0] pin_s0;
		logic [4:0] pin_s1;
		logic [3:0] bt_s;
		logic [1:0] bv_s;
		logic [2:0] et_s;
		mfr_pkg::rx_state_e state;
		logic [mfr_pkg::MATCH_W-1:0] hist;
		logic invert;
		logic [17:0] on_cnt;
		logic [17:0] settle_cnt;
		logic [8:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] pad_cnt;
		logic out_valid;
		logic out_bit;
		logic rx_on;
		logic cfg_mode;
		logic spi_master;
	} rcv_s;

	rcv_s s;
	rcv_s next_s;

	logic link_bit_tog;
	logic link_bit_val;
	logic link_eom_tog;
	logic cfg_n;
	logic wake_hi;
	logic wake_lo;
	logic osc_tick;
	logic raw_sync;
	logic bit_evt;
	logic bit_val;
	logic eom_evt;
	logic [mfr_pkg::MATCH_W-1:0] hist_new;
	logic [1:0] id_hit;
	logic [1:0] hdr_hit;
	logic strobe_osc_enable;
	logic bypass;

	// Link-domain decoder
	mfr_manchester_decoder mfr_manchester_decoder_inst (
		.link_clk_i(link_clk_i),
		.srst_i(srst_i),
		.rx_on_i(s.rx_on),
		.raw_i(raw_data_i),
		.bit_toggle_o(link_bit_tog),
		.bit_value_o(link_bit_val),
		.eom_toggle_o(link_eom_tog)
	);

	// Serial output stage
	mfr_spi_shifter mfr_spi_shifter_inst (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.bypass_i(bypass),
		.raw_i(raw_sync),
		.bit_valid_i(s.out_valid),
		.bit_i(s.out_bit),
		.mosi_o(mosi_o),
		.sclk_o(sclk_o)
	);

	// Synchronised pins and crossed events
	assign cfg_n = s.pin_s1[0];
	assign wake_hi = s.pin_s1[1];
	assign wake_lo = s.pin_s1[2];
	assign osc_tick = s.pin_s1[3];
	assign raw_sync = s.pin_s1[4];
	assign bit_evt = s.bt_s[3] ^ s.bt_s[2]; // Data had an extra cycle to settle
	assign bit_val = s.bv_s[1];
	assign eom_evt = s.et_s[2] ^ s.et_s[1];
	assign strobe_osc_enable = strobe_osc_enable_i;
	assign bypass = !decoder_enable_i && s.rx_on; // [RULE1]

	// Sliding window over the newest decoded bits
	assign hist_new = {s.hist[mfr_pkg::MATCH_W-2:0], bit_val}; // [RULE27]
	assign id_hit = mfr_pkg::pattern_hit(hist_new, id_pattern_i, id_length_field_i); // [RULE7]
	assign hdr_hit = mfr_pkg::pattern_hit(hist_new, header_pattern_i,
		header_length_field_i); // [RULE9]

	// Sequencer, matching and byte bookkeeping
	always_comb
	begin
		next_s = s;
		next_s.pin_s0 = {raw_data_i, osc_wake_i, strobe_low_i, strobe_high_i, config_select_n_i};
		next_s.pin_s1 = s.pin_s0;
		next_s.bt_s = {s.bt_s[2:0], link_bit_tog};
		next_s.bv_s = {s.bv_s[0], link_bit_val};
		next_s.et_s = {s.et_s[1:0], link_eom_tog};
		next_s.out_valid = 1'b0;
		if (s.settle_cnt != '0)
			next_s.settle_cnt = s.settle_cnt - 18'h00001;
		if (bit_evt && s.settle_cnt == '0) // [RULE22]
			next_s.hist = hist_new;
		if (srst_i)
		begin
			next_s.state = mfr_pkg::ST_STANDBY;
			next_s.hist = '0;
			next_s.invert = 1'b0;
			next_s.on_cnt = '0;
			next_s.settle_cnt = '0;
			next_s.bit_cnt = '0;
			next_s.byte_cnt = '0;
			next_s.pad_cnt = '0;
			next_s.out_bit = 1'b0;
		end
		else if (!cfg_n)
			next_s.state = mfr_pkg::ST_CONFIG; // [RULE21]
		else if (s.state != mfr_pkg::ST_CONFIG && s.state != mfr_pkg::ST_STANDBY
			&& s.state != mfr_pkg::ST_OFF && strobe_osc_enable && wake_lo)
			next_s.state = mfr_pkg::ST_OFF; // [RULE18]
		else if (s.state != mfr_pkg::ST_CONFIG && s.state != mfr_pkg::ST_STANDBY
			&& s.state != mfr_pkg::ST_OFF && !strobe_osc_enable && !wake_hi)
			next_s.state = mfr_pkg::ST_STANDBY; // [RULE21]
		else
		begin
			case (s.state)
				mfr_pkg::ST_CONFIG:
				begin
					next_s.state = strobe_osc_enable ? mfr_pkg::ST_OFF : mfr_pkg::ST_STANDBY;
				end
				mfr_pkg::ST_STANDBY:
				begin
					if (strobe_osc_enable)
						next_s.state = mfr_pkg::ST_OFF;
					else if (wake_hi) // [RULE19]
					begin
						next_s.state = mfr_pkg::ST_ID_WAIT;
						next_s.settle_cnt = 18'(SETTLE_CYCLES); // [RULE22]
						next_s.hist = '0;
					end
				end
				mfr_pkg::ST_OFF:
				begin
					if (!strobe_osc_enable)
						next_s.state = mfr_pkg::ST_STANDBY;
					else if (wake_lo)
						next_s.state = mfr_pkg::ST_OFF; // Held off by the pin [RULE13]
					else if (wake_hi || osc_tick) // [RULE18]
					begin
						next_s.state = mfr_pkg::ST_ID_WAIT;
						next_s.on_cnt = 18'(receiver_on_time_field_i) * 18'(ON_UNIT_CYCLES);
						next_s.settle_cnt = 18'(SETTLE_CYCLES); // [RULE22]
						next_s.hist = '0;
					end
				end
				mfr_pkg::ST_ID_WAIT:
				begin
					if (s.on_cnt != '0)
						next_s.on_cnt = s.on_cnt - 18'h00001;
					if (decoder_enable_i && bit_evt && s.settle_cnt == '0
						&& id_hit != 2'b00) // [RULE8] [RULE14] [RULE20]
					begin
						next_s.state = mfr_pkg::ST_HDR_WAIT;
						next_s.bit_cnt = '0;
					end
					else if (strobe_osc_enable && s.on_cnt == '0 && !wake_hi)
						next_s.state = mfr_pkg::ST_OFF; // [RULE14]
				end
				mfr_pkg::ST_HDR_WAIT:
				begin
					if (bit_evt && hdr_hit != 2'b00) // [RULE9] [RULE20]
					begin
						next_s.state = mfr_pkg::ST_DATA;
						next_s.invert = hdr_hit == 2'b10; // [RULE9]
						next_s.byte_cnt = '0;
					end
					else if (bit_evt)
					begin
						next_s.bit_cnt = s.bit_cnt + 9'h001;
						if (strobe_osc_enable && s.bit_cnt + 9'h001 >= mfr_pkg::HDR_TIMEOUT_BITS)
							next_s.state = mfr_pkg::ST_OFF; // [RULE15]
					end
				end
				mfr_pkg::ST_DATA:
				begin
					if (eom_evt) // [RULE16]
					begin
						if (s.byte_cnt != '0)
						begin
							next_s.state = mfr_pkg::ST_FLUSH; // [RULE17]
							next_s.pad_cnt = '0;
						end
						else
							next_s.state = strobe_osc_enable ? mfr_pkg::ST_OFF : mfr_pkg::ST_ID_WAIT;
					end
					else if (bit_evt)
					begin
						next_s.out_valid = 1'b1; // First received goes first [RULE26]
						next_s.out_bit = bit_val ^ s.invert; // [RULE9] [RULE16]
						next_s.byte_cnt = s.byte_cnt + 3'h1;
					end
				end
				mfr_pkg::ST_FLUSH:
				begin
					if (s.pad_cnt != '0)
						next_s.pad_cnt = s.pad_cnt - 8'h01;
					else if (s.byte_cnt == 3'h0) // Last pulse over, stay master until then
						next_s.state = strobe_osc_enable ? mfr_pkg::ST_OFF : mfr_pkg::ST_ID_WAIT;
					else
					begin
						next_s.out_valid = 1'b1; // Dummy bit [RULE17]
						next_s.out_bit = 1'b0;
						next_s.byte_cnt = s.byte_cnt + 3'h1;
						next_s.pad_cnt = 8'(mfr_pkg::PAD_BIT_CYCLES - 1);
					end
				end
				default:
				begin
					next_s.state = mfr_pkg::ST_STANDBY;
				end
			endcase
		end
		next_s.rx_on = next_s.state == mfr_pkg::ST_ID_WAIT
			|| next_s.state == mfr_pkg::ST_HDR_WAIT
			|| next_s.state == mfr_pkg::ST_DATA
			|| next_s.state == mfr_pkg::ST_FLUSH; // [RULE13]
		next_s.cfg_mode = next_s.state == mfr_pkg::ST_CONFIG;
		next_s.spi_master = decoder_enable_i && (next_s.state == mfr_pkg::ST_DATA
			|| next_s.state == mfr_pkg::ST_FLUSH);
		if (next_s.state != mfr_pkg::ST_DATA && next_s.state != mfr_pkg::ST_FLUSH)
			next_s.invert = 1'b0;
	end

	// State register
	always_ff @(posedge core_clk_i)
	begin
		s <= next_s;
	end

	assign rx_on_o = s.rx_on;
	assign config_mode_o = s.cfg_mode;
	assign spi_master_o = s.spi_master;
	assign data_inverted_o = s.invert;

endmodule // manchester_frame_receiver
`default_nettype wire

// ===== mfr_frame_receiver_properties.sv
// Pin-level checks for the Manchester frame receiver, bound to its top module.
// Assumes pins change on core clock edges and reset is synchronous, active high.
`timescale 1ns/100ps
`default_nettype none
module mfr_frame_checker #(
	parameter int ON_UNIT_CYCLES = 16, // Core clocks per on-time unit
	parameter int SETTLE_CYCLES = 20 // Core clocks of settling
) (
	input wire logic core_clk_i, // Core clock
	input wire logic srst_i, // Synchronous reset
	input wire logic raw_data_i, // Raw data pin
	input wire logic decoder_enable_i, // Data manager enable
	input wire logic strobe_osc_enable_i, // Strobe oscillator enable
	input wire logic config_select_n_i, // Config select pin
	input wire logic strobe_high_i, // Wake pin high
	input wire logic strobe_low_i, // Wake pin low
	input wire logic [3:0] receiver_on_time_field_i, // On time in units
	input wire logic mosi_o, // Serial data
	input wire logic sclk_o, // Serial clock
	input wire logic rx_on_o, // Receiver on
	input wire logic config_mode_o, // Config mode
	input wire logic spi_master_o // Serial master active
);
	logic [7:0] hi_cnt;
	int on_cnt;

	// Length of the current clock pulse and of the current on stretch
	always_ff @(posedge core_clk_i)
	begin
		hi_cnt <= (srst_i || !sclk_o) ? 8'h00 : hi_cnt + 8'h01;
		on_cnt <= (srst_i || !rx_on_o) ? 0 : on_cnt + 1;
	end

	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	// Receiver on with decoding bypassed, and wake pin held low under the oscillator
	sequence s_bypass;
		(!decoder_enable_i && rx_on_o)[*4];
	endsequence
	sequence s_osc_held_off;
		(strobe_osc_enable_i && strobe_low_i)[*4];
	endsequence

	a_bypass_raw_copy: assert property (s_bypass |-> mosi_o == $past(raw_data_i, 3))
		else $error("serial data does not follow raw data");
	a_bypass_no_clock: assert property ((!decoder_enable_i)[*3] |-> !sclk_o && !spi_master_o)
		else $error("clock or master active while bypassed");
	a_config_forced: assert property ((!config_select_n_i)[*4] |-> config_mode_o && !rx_on_o)
		else $error("config select low did not force config");
	a_sclk_high_time: assert property ($fell(sclk_o) |-> hi_cnt == 8'h50)
		else $error("serial clock pulse not 80 cycles");
	a_mosi_steady: assert property ($past(sclk_o) |-> $stable(mosi_o))
		else $error("serial data moved while clock high or falling");
	a_clock_as_master: assert property ($rose(sclk_o) |-> spi_master_o)
		else $error("clock pulse outside data output");
	a_wake_low_off: assert property (s_osc_held_off |-> !rx_on_o)
		else $error("receiver on with wake pin low");
	a_standby_no_wake: assert property ((!strobe_osc_enable_i && !strobe_high_i)[*4] |-> !rx_on_o)
		else $error("receiver on in standby");
	a_wake_turns_on: assert property ((config_select_n_i && strobe_high_i && !strobe_low_i)[*6]
		|-> rx_on_o)
		else $error("wake pin high did not turn receiver on");
	a_on_time_span: assert property ($fell(rx_on_o) && strobe_osc_enable_i && !strobe_low_i
		&& !strobe_high_i && config_select_n_i
		|-> on_cnt >= ON_UNIT_CYCLES * int'(receiver_on_time_field_i))
		else $error("receiver turned off before on time");
endmodule // mfr_frame_checker

bind manchester_frame_receiver mfr_frame_checker #(
	.ON_UNIT_CYCLES(ON_UNIT_CYCLES),
	.SETTLE_CYCLES(SETTLE_CYCLES)
) mfr_frame_checker_inst (
	.core_clk_i(core_clk_i),
	.srst_i(srst_i),
	.raw_data_i(raw_data_i),
	.decoder_enable_i(decoder_enable_i),
	.strobe_osc_enable_i(strobe_osc_enable_i),
	.config_select_n_i(config_select_n_i),
	.strobe_high_i(strobe_high_i),
	.strobe_low_i(strobe_low_i),
	.receiver_on_time_field_i(receiver_on_time_field_i),
	.mosi_o(mosi_o),
	.sclk_o(sclk_o),
	.rx_on_o(rx_on_o),
	.config_mode_o(config_mode_o),
	.spi_master_o(spi_master_o)
);
`default_nettype wire

// ===== mfr_manchester_decoder.sv
// Manchester decoder and clock recovery on the digital link clock.
// Assumes srst_i and rx_on_i come from the core clock domain and raw_i from the demodulator pin.
`timescale 1ns/100ps
`default_nettype none
module mfr_manchester_decoder (
	input wire logic link_clk_i, // Digital link clock
	input wire logic srst_i, // Core-domain reset, synchronised here
	input wire logic rx_on_i, // Core-domain receiver on level
	input wire logic raw_i, // Raw demodulated data pin
	output logic bit_toggle_o, // Toggles per decoded bit
	output logic bit_value_o, // Value of last decoded bit
	output logic eom_toggle_o // Toggles per end of message
);

	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] on_sync;
		logic [1:0] raw_sync;
		logic raw_prev;
		logic [mfr_pkg::RUN_W-1:0] run;
		logic [mfr_pkg::RUN_W-1:0] half;
		logic mid;
		logic locked;
		logic bit_tog;
		logic bit_val;
		logic eom_tog;
	} dec_s;

	dec_s s;
	dec_s next_s;
	logic [mfr_pkg::RUN_W+1:0] run_x;
	logic [mfr_pkg::RUN_W+1:0] half_x;

	// Pulse-width classification and bit emission
	always_comb
	begin
		next_s = s;
		run_x = {2'b00, s.run};
		half_x = {2'b00, s.half};
		next_s.rst_sync = {s.rst_sync[0], srst_i};
		next_s.on_sync = {s.on_sync[0], rx_on_i};
		next_s.raw_sync = {s.raw_sync[0], raw_i};
		if (s.rst_sync[1] || !s.on_sync[1])
		begin
			next_s.raw_prev = s.raw_sync[1];
			next_s.run = '0;
			next_s.half = mfr_pkg::HALF_INIT;
			next_s.mid = 1'b0;
			next_s.locked = 1'b0;
			// Known toggles without a long reset; costs at most one stray bit
			next_s.bit_tog = 1'b0;
			next_s.bit_val = 1'b0;
			next_s.eom_tog = 1'b0;
		end
		else if (s.raw_sync[1] != s.raw_prev)
		begin
			next_s.raw_prev = s.raw_sync[1];
			next_s.run = mfr_pkg::RUN_W'(1);
			if (run_x < half_x + (half_x >> 1)) // One half-bit
			begin
				next_s.half = s.run; // [RULE25]
				next_s.mid = !s.mid;
				if (!s.mid && s.locked)
				begin
					next_s.bit_val = s.raw_prev; // First half carries data [RULE2]
					next_s.bit_tog = !s.bit_tog;
				end
			end
			else if (run_x < (half_x << 1) + (half_x >> 1)) // Two half-bits
			begin
				next_s.half = s.run >> 1; // Keeps tracking the rate [RULE25]
				next_s.mid = 1'b1;
				next_s.locked = 1'b1;
				next_s.bit_val = s.raw_prev; // [RULE2]
				next_s.bit_tog = !s.bit_tog;
			end
			else
			begin
				next_s.mid = 1'b0;
				next_s.locked = 1'b0;
				if (s.locked)
					next_s.eom_tog = !s.eom_tog; // Violation ends message [RULE11]
			end
		end
		else
		begin
			if (s.run != '1)
				next_s.run = s.run + mfr_pkg::RUN_W'(1);
			if (s.locked && run_x >= (half_x << 1) + half_x)
			begin
				next_s.locked = 1'b0;
				next_s.eom_tog = !s.eom_tog; // Level held too long [RULE11]
			end
		end
	end

	// State register
	always_ff @(posedge link_clk_i)
	begin
		s <= next_s;
	end

	assign bit_toggle_o = s.bit_tog;
	assign bit_value_o = s.bit_val;
	assign eom_toggle_o = s.eom_tog;

endmodule // mfr_manchester_decoder
`default_nettype wire

// ===== mfr_pkg.sv
// Shared constants, state codes and pattern helpers for the Manchester frame receiver.
// Assumes a 100 MHz core clock and a free-running 160 ns digital link clock.
package mfr_pkg;

	// Clock periods
	localparam int CORE_CLK_NS = 10;
	localparam int DIG_CLK_NS = 160;

	// Receiver on time is the on-time field times this many digital clocks
	localparam int ON_UNIT_DIG = 512;
	localparam int ON_UNIT_CYCLES_DFLT = ON_UNIT_DIG * DIG_CLK_NS / CORE_CLK_NS;

	// Settling interval after the receiver turns on (least time, rounds up)
	localparam int SETTLE_TIME_NS = 1000000;
	localparam int SETTLE_CYCLES_DFLT = (SETTLE_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

	// Serial output clock high time and dummy-bit pacing (least times, round up)
	localparam int SCLK_HIGH_NS = 800;
	localparam int SCLK_HIGH_CYCLES = (SCLK_HIGH_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int PAD_BIT_NS = 1600;
	localparam int PAD_BIT_CYCLES = (PAD_BIT_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

	// Header search time-out in received bits
	localparam logic [8:0] HDR_TIMEOUT_BITS = 9'h100;

	// Pattern store width and length step per length-field code
	localparam int MATCH_W = 16;
	localparam logic [4:0] MATCH_STEP = 5'h04;

	// Pulse-width measurement
	localparam int RUN_W = 12;
	localparam logic [RUN_W-1:0] HALF_INIT = 12'hfff;

	// Receive sequencer states
	typedef enum logic [2:0] {
		ST_CONFIG = 3'b000,
		ST_STANDBY = 3'b001,
		ST_OFF = 3'b010,
		ST_ID_WAIT = 3'b011,
		ST_HDR_WAIT = 3'b100,
		ST_DATA = 3'b101,
		ST_FLUSH = 3'b110
	} rx_state_e;

	// Match length in bits for a two-bit length field
	function automatic logic [4:0] match_len(input logic [1:0] field);
		match_len = 5'(({3'h0, field} + 5'h01) * MATCH_STEP);
	endfunction

	// Compare recent bits with a pattern; returns {complement hit, true hit}
	function automatic logic [1:0] pattern_hit(input logic [MATCH_W-1:0] hist,
		input logic [MATCH_W-1:0] pat, input logic [1:0] field);
		logic [MATCH_W-1:0] mask;
		mask = MATCH_W'((32'h1 << match_len(field)) - 32'h1);
		pattern_hit = {((~hist ^ pat) & mask) == '0, ((hist ^ pat) & mask) == '0};
	endfunction

endpackage

// ===== mfr_spi_shifter.sv
// Serial output stage: one clock pulse per bit, or raw bypass.
// Assumes bit_valid_i pulses no faster than one clock high time apart.
`timescale 1ns/100ps
`default_nettype none
module mfr_spi_shifter (
	input wire logic core_clk_i, // Core clock
	input wire logic srst_i, // Synchronous reset
	input wire logic bypass_i, // Pass raw data through
	input wire logic raw_i, // Synchronised raw data
	input wire logic bit_valid_i, // Bit to shift out
	input wire logic bit_i, // Bit value
	output logic mosi_o, // Serial data
	output logic sclk_o // Serial clock
);

	typedef struct packed {
		logic mosi;
		logic sclk;
		logic [7:0] cnt;
	} shf_s;

	shf_s s;
	shf_s next_s;

	// Drive data with clock high; receiver samples on the fall
	always_comb
	begin
		next_s = s;
		if (srst_i)
			next_s = '0;
		else if (bypass_i)
		begin
			next_s.mosi = raw_i; // [RULE1]
			next_s.sclk = 1'b0; // [RULE1]
			next_s.cnt = '0;
		end
		else if (bit_valid_i)
		begin
			next_s.mosi = bit_i; // Stable across the falling edge [RULE24]
			next_s.sclk = 1'b1;
			next_s.cnt = 8'(mfr_pkg::SCLK_HIGH_CYCLES - 1);
		end
		else if (s.cnt != '0)
			next_s.cnt = s.cnt - 8'h01;
		else
			next_s.sclk = 1'b0;
	end

	// State register
	always_ff @(posedge core_clk_i)
	begin
		s <= next_s;
	end

	assign mosi_o = s.mosi;
	assign sclk_o = s.sclk;

endmodule // mfr_spi_shifter
`default_nettype wire

// ===== mfr_spi_sink.sv
// Controller-side serial port model taking decoded bits from the receiver.
// Assumes clock idles low and data is read on its falling edge.
`timescale 1ns/100ps
`default_nettype none
module mfr_spi_sink (
	input wire logic sclk_i, // Serial clock from receiver
	input wire logic mosi_i, // Serial data from receiver
	input wire logic clear_i, // Start a new capture
	output logic [15:0] shift_o, // Bits taken, latest lowest
	output logic [7:0] count_o // Bits taken so far
);
	// Take each bit on the falling clock edge, first bit ends on top
	always @(negedge sclk_i or posedge clear_i)
	begin
		if (clear_i)
		begin
			shift_o <= 16'h0000;
			count_o <= 8'h00;
		end
		else
		begin
			shift_o <= {shift_o[14:0], mosi_i};
			count_o <= count_o + 8'h01;
		end
	end
endmodule // mfr_spi_sink
`default_nettype wire

// ===== tb_manchester_frame_receiver.sv
// Self-checking bench for the Manchester frame receiver.
// Assumes the checker binds itself and the serial sink model sits on the output.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module tb_manchester_frame_receiver;
	localparam int ON_UNIT = 16; // Shortened on-time unit
	localparam int SETTLE = 20; // Shortened settling
	localparam int HALF = 128; // Core clocks per half bit
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	logic raw_data = 1'b0;
	logic decoder_enable = 1'b0;
	logic osc_enable = 1'b0;
	logic config_n = 1'b1;
	logic wake_high = 1'b0;
	logic wake_low = 1'b0;
	logic osc_wake = 1'b0;
	logic sink_clear = 1'b1;
	logic mosi, sclk, rx_on, config_mode, spi_master, data_inverted;
	logic [15:0] sink_bits;
	logic [7:0] sink_count;
	int mismatches = 0;
	int checked = 0;

	// Core clock, and a link clock of its own phase
	always #5 core_clk = ~core_clk;
	initial
	begin
		#3;
		forever #80 link_clk = ~link_clk;
	end

	manchester_frame_receiver #(
		.ON_UNIT_CYCLES(ON_UNIT),
		.SETTLE_CYCLES(SETTLE)
	) manchester_frame_receiver_inst (
		.core_clk_i(core_clk), .srst_i(srst), .link_clk_i(link_clk), .raw_data_i(raw_data),
		.decoder_enable_i(decoder_enable), .strobe_osc_enable_i(osc_enable),
		.config_select_n_i(config_n), .strobe_high_i(wake_high), .strobe_low_i(wake_low),
		.osc_wake_i(osc_wake), .id_pattern_i(16'h003c), .id_length_field_i(2'h1),
		.header_pattern_i(16'h0096), .header_length_field_i(2'h1),
		.receiver_on_time_field_i(4'h2), .mosi_o(mosi), .sclk_o(sclk), .rx_on_o(rx_on),
		.config_mode_o(config_mode), .spi_master_o(spi_master), .data_inverted_o(data_inverted)
	);
	mfr_spi_sink mfr_spi_sink_inst (
		.sclk_i(sclk), .mosi_i(mosi), .clear_i(sink_clear), .shift_o(sink_bits), .count_o(sink_count)
	);

	// Verdict and end of run
	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Bounded wait for a level; running out ends the run
	task automatic wait_level(ref logic s, input logic v, input int lim, input string what);
		for (int i = 0; s !== v && i < lim; i++)
			step(1);
		if (s !== v)
		begin
			`CHECK(what, v, s)
			finish_test();
		end
	endtask

	// Manchester sender: data half then inverse half, even duty
	task automatic send_bit(input logic b);
		raw_data <= b;
		step(HALF);
		raw_data <= ~b;
		step(HALF);
	endtask
	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			send_bit(v[i]);
	endtask

	task automatic test_config();
		config_n <= 1'b0;
		step(6);
		`CHECK("config_mode", 1'b1, config_mode)
		`CHECK("rx_on in config", 1'b0, rx_on)
		config_n <= 1'b1;
		step(8);
		`CHECK("config released", 1'b0, config_mode)
		`CHECK("standby rx_on", 1'b0, rx_on)
		$display("test_config done");
	endtask

	task automatic test_bypass();
		wake_high <= 1'b1;
		wait_level(rx_on, 1'b1, 20, "bypass rx_on");
		for (int i = 0; i < 4; i++)
		begin
			raw_data <= i[0];
			step(6);
			`CHECK("raw on mosi", i[0], mosi)
			`CHECK("sclk bypass", 1'b0, sclk)
		end
		wake_high <= 1'b0;
		wait_level(rx_on, 1'b0, 20, "standby again");
		$display("test_bypass done");
	endtask

	task automatic test_strobe_osc();
		int n;
		decoder_enable <= 1'b1;
		osc_enable <= 1'b1;
		wake_low <= 1'b1;
		step(4);
		osc_wake <= 1'b1;
		step(4);
		osc_wake <= 1'b0;
		step(6);
		`CHECK("held off", 1'b0, rx_on)
		wake_low <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			step(4);
			osc_wake <= 1'b1;
			step(4);
			osc_wake <= 1'b0;
			wait_level(rx_on, 1'b1, 10, "osc wake on");
		end
		for (n = 8; rx_on === 1'b1 && n < 200; n++) // Eight cycles on already
			step(1);
		`CHECK("on time", 1'b1, n >= 2 * ON_UNIT)
		`CHECK("off after on time", 1'b0, rx_on)
		osc_wake <= 1'b1;
		step(4);
		osc_wake <= 1'b0;
		wait_level(rx_on, 1'b1, 10, "osc wake again");
		wake_low <= 1'b1;
		step(6);
		`CHECK("wake low forces off", 1'b0, rx_on)
		wake_low <= 1'b0;
		osc_enable <= 1'b0;
		config_n <= 1'b0;
		step(6);
		config_n <= 1'b1;
		step(6);
		$display("test_strobe_osc done");
	endtask

	// Frame: preamble, identifier, header, data, 3 loose bits, end marker
	task automatic test_frame(input logic inv);
		sink_clear <= 1'b1;
		wake_high <= 1'b1;
		step(1);
		sink_clear <= 1'b0;
		wait_level(rx_on, 1'b1, 20, "frame rx_on");
		step(SETTLE + 4); // Wake held over settling and identifiers
		send_byte(8'hff);
		send_byte(8'haa);
		send_byte(inv ? 8'hc3 : 8'h3c);
		send_byte(inv ? 8'h69 : 8'h96);
		send_byte(8'ha5);
		`CHECK("spi_master", 1'b1, spi_master)
		`CHECK("data_inverted", inv, data_inverted)
		send_bit(1'b1);
		send_bit(1'b0);
		send_bit(1'b1);
		step(3 * HALF);
		wait_level(spi_master, 1'b0, 4000, "output stop");
		step(100);
		`CHECK("bit count", 8'h10, sink_count)
		`CHECK("first byte", inv ? 8'h5a : 8'ha5, sink_bits[15:8])
		`CHECK("loose bits", inv ? 3'h2 : 3'h5, sink_bits[7:5])
		$display("test_frame done");
	endtask

	// Short reset; the decoder clears itself while the receiver is off
	initial
	begin
		step(5);
		srst <= 1'b0;
		sink_clear <= 1'b0;
		step(4);
		test_config();
		test_bypass();
		test_strobe_osc();
		test_frame(1'b0);
		test_frame(1'b1);
		finish_test();
	end
endmodule // tb_manchester_frame_receiver
`default_nettype wire
